// *** verilog/resolver_converter_config_regs.sv ***
/*
 Configuration and fault register bank of a resolver converter:
 tracking-loss thresholds, excitation word and accumulator, control
 register, soft reset and fault register.
 Assumes the port front end delivers each latched byte as a one-cycle
 strobe on this clock; mode, sample and resolution pins are async.
*/
`timescale 1ns/1ns
`default_nettype none
module resolver_converter_config_regs (
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      mode_select_a_i,
	input  wire logic                      mode_select_b_i,
	input  wire logic                      sample_i,
	input  wire logic                      output_resolution_sel_lo_i,
	input  wire logic                      output_resolution_sel_hi_i,
	input  wire logic                      wr_stb_i,
	input  wire logic [7:0]                wr_byte_i,
	input  wire logic [6:0]                track_err_i,
	input  wire logic [7:0]                fault_src_i,
	output logic      [7:0]                rd_byte_o,
	output resolver_cfg_pkg::ctrl_t        control_o,
	output logic      [1:0]                out_res_o,
	output logic      [resolver_cfg_pkg::PHASE_BITS-1:0] exc_phase_o,
	output logic                           loop_restart_o,
	output logic                           config_mode_o,
	output logic                           tracking_loss_n_o,
	output logic                           signal_degradation_n_o
);
	localparam int PHASE_W = resolver_cfg_pkg::PHASE_BITS;

	// Pin synchroniser: mode a, mode b, sample, res lo, res hi
	logic [4:0] pin_s1_r;            // First stage, read by stage two only
	logic [4:0] pin_s2_r;            // Second stage
	logic [4:0] pin_s3_r;            // Third stage
	logic [4:0] pin_r;               // Filtered pin levels
	logic [4:0] pin_nxt;
	logic       sample_prev_r;       // Last filtered sample level

	// Register storage, parity in bit 7 of the four configuration bytes
	logic [7:0] tl_high_r;
	logic [7:0] tl_low_r;
	logic [7:0] exc_r;
	logic [7:0] ctrl_r;
	logic [7:0] addr_r;              // Last written address
	logic [7:0] fault_r;             // Latched fault causes
	logic [7:0] ind_r;               // Sticky fault indications
	logic       fault_read_r;        // Fault register was read
	logic       parity_err_r;        // Readback mismatch seen
	logic       lot_r;               // Tracking-loss state
	logic [PHASE_W-1:0] acc_r;       // Excitation phase accumulator
	logic [1:0] out_res_r;

	// Decode wires
	wire        cfg_mode   = pin_r[0] & pin_r[1];
	wire        sample_fall = sample_prev_r & ~pin_r[2];
	wire        addr_wr    = wr_stb_i & cfg_mode & wr_byte_i[resolver_cfg_pkg::FLAG_BIT];
	wire        data_wr    = wr_stb_i & cfg_mode & ~wr_byte_i[resolver_cfg_pkg::FLAG_BIT];
	wire        soft_rst   = addr_wr & (wr_byte_i == resolver_cfg_pkg::ADDR_SRST);
	wire [7:0]  wdata      = resolver_cfg_pkg::with_parity(wr_byte_i[6:0]);
	wire        wr_high    = data_wr & (addr_r == resolver_cfg_pkg::ADDR_TL_HIGH);
	wire        wr_low     = data_wr & (addr_r == resolver_cfg_pkg::ADDR_TL_LOW);
	wire        wr_exc     = data_wr & (addr_r == resolver_cfg_pkg::ADDR_EXC);
	wire        wr_ctrl    = data_wr & (addr_r == resolver_cfg_pkg::ADDR_CTRL);
	wire        err_over   = track_err_i > tl_high_r[6:0];
	wire        err_under  = track_err_i < tl_low_r[6:0];
	wire        rd_fault   = addr_wr & (wr_byte_i == resolver_cfg_pkg::ADDR_FAULT);
	wire        clr_ind    = sample_fall & fault_read_r;
	wire        lot_nxt    = err_over ? 1'b1 : (err_under ? 1'b0 : lot_r);

	// Live fault vector, tracking and parity from this block
	wire [7:0]  fault_live = {fault_src_i[7:4], lot_r, fault_src_i[2:1], parity_err_r};

	// Readback of a stored byte with parity check
	logic [7:0] rb_sel;
	logic       rb_rw;
	always_comb begin
		rb_sel = 8'h00;
		rb_rw  = 1'b1;
		case (wr_byte_i)
			resolver_cfg_pkg::ADDR_TL_HIGH: rb_sel = tl_high_r;
			resolver_cfg_pkg::ADDR_TL_LOW:  rb_sel = tl_low_r;
			resolver_cfg_pkg::ADDR_EXC:     rb_sel = exc_r;
			resolver_cfg_pkg::ADDR_CTRL:    rb_sel = ctrl_r;
			default:                        rb_rw  = 1'b0;
		endcase
	end
	wire        rb_mismatch = rb_rw & ((^rb_sel[6:0]) != rb_sel[7]);
	wire [7:0]  rb_byte  = rb_rw ? {rb_mismatch, rb_sel[6:0]} :
		(rd_fault ? fault_r : 8'h00);

	// Filter: a bit moves once stages two and three agree
	assign pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));

	// Pin synchroniser chain
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_r      <= 5'h00;
			pin_s2_r      <= 5'h00;
			pin_s3_r      <= 5'h00;
			pin_r         <= 5'h00;
			sample_prev_r <= 1'b0;
		end else begin
			pin_s1_r      <= {output_resolution_sel_hi_i, output_resolution_sel_lo_i,
				sample_i, mode_select_b_i, mode_select_a_i};
			pin_s2_r      <= pin_s1_r;
			pin_s3_r      <= pin_s2_r;
			pin_r         <= pin_nxt;
			sample_prev_r <= pin_r[2];
		end
	end

	// Address latch; only addresses move it
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_r <= resolver_cfg_pkg::ADDR_FAULT;
		end else if (addr_wr) begin
			addr_r <= wr_byte_i; // RULE_14
		end
	end

	// Configuration registers, written with parity; other targets ignored
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tl_high_r <= resolver_cfg_pkg::with_parity(resolver_cfg_pkg::TL_HIGH_DEFAULT); // RULE_03
			tl_low_r  <= resolver_cfg_pkg::with_parity(resolver_cfg_pkg::TL_LOW_DEFAULT);
			exc_r     <= resolver_cfg_pkg::with_parity(resolver_cfg_pkg::FCW_DEFAULT); // RULE_06
			ctrl_r    <= resolver_cfg_pkg::with_parity(resolver_cfg_pkg::CTRL_DEFAULT); // RULE_07
		end else begin
			if (wr_high) begin
				tl_high_r <= wdata; // RULE_01
			end
			if (wr_low) begin
				tl_low_r <= wdata; // RULE_15
			end
			if (wr_exc) begin
				exc_r <= wdata;
			end
			if (wr_ctrl) begin
				ctrl_r <= wdata; // RULE_08
			end
		end
	end

	// Output register, loaded when an address is written
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_byte_o <= 8'h00;
		end else if (addr_wr) begin
			rd_byte_o <= rb_byte; // RULE_15
		end
	end

	// Tracking-loss detector with hysteresis
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lot_r <= 1'b0;
		end else if (soft_rst) begin
			lot_r <= 1'b0;
		end else begin
			lot_r <= lot_nxt; // RULE_02
		end
	end

	// Parity error flag; a new mismatch wins over a clear
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			parity_err_r <= 1'b0;
		end else if (addr_wr & rb_mismatch) begin
			parity_err_r <= 1'b1;
		end else if (soft_rst | clr_ind) begin
			parity_err_r <= 1'b0;
		end
	end

	// Fault register, latched at each sample falling edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_r <= 8'h00;
		end else if (soft_rst) begin
			fault_r <= 8'h00; // RULE_16
		end else if (sample_fall) begin
			fault_r <= fault_live; // RULE_19
		end
	end

	// Indications: set by live faults, cleared by the first sample falling edge after a fault read
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ind_r        <= 8'h00;
			fault_read_r <= 1'b0;
		end else if (soft_rst) begin
			ind_r        <= fault_live;
			fault_read_r <= 1'b0;
		end else begin
			ind_r        <= fault_live | (clr_ind ? 8'h00 : ind_r); // RULE_22
			fault_read_r <= rd_fault | (fault_read_r & ~sample_fall);
		end
	end

	// Excitation accumulator; soft reset restarts its phase
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_r <= '0;
		end else if (soft_rst) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_r + PHASE_W'(exc_r[6:0]); // RULE_04
		end
	end

	// Mode outputs from flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_res_r      <= resolver_cfg_pkg::RES_12;
			loop_restart_o <= 1'b0;
		end else begin
			out_res_r      <= cfg_mode ? // RULE_13
				resolver_cfg_pkg::res_code(ctrl_r[0], ctrl_r[1]) :
				resolver_cfg_pkg::res_code(pin_r[3], pin_r[4]); // RULE_20
			loop_restart_o <= soft_rst;
		end
	end

	// Control fields drive lock range, hysteresis and encoder steps
	assign control_o   = resolver_cfg_pkg::ctrl_t'(ctrl_r[6:0]); // RULE_09 RULE_10 RULE_12
	assign out_res_o   = out_res_r;
	assign exc_phase_o = acc_r;
	assign config_mode_o = cfg_mode;

	// Pins go low on a tracking or degradation class fault
	assign tracking_loss_n_o = ~(ind_r[resolver_cfg_pkg::FLT_TRACK] | // RULE_18
		ind_r[resolver_cfg_pkg::FLT_VELO] | ind_r[resolver_cfg_pkg::FLT_PHASE]);
	assign signal_degradation_n_o = ~(|ind_r[7:4] | ind_r[resolver_cfg_pkg::FLT_PARITY]);

	// Checks
	a_lot_rises: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_02
		(err_over && !soft_rst) |=> lot_r)
		else $error("tracking loss not raised above high threshold");

	a_lot_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_02
		(lot_r && !err_under && !soft_rst) |=> lot_r)
		else $error("tracking loss dropped before low threshold");

	a_addr_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_14
		addr_wr |=> (addr_r == $past(wr_byte_i)))
		else $error("address byte not latched");

	a_ctrl_parity: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_15
		wr_ctrl |=> (ctrl_r[7] == ^ctrl_r[6:0]) && (ctrl_r[6:0] == $past(wr_byte_i[6:0])))
		else $error("control byte stored without parity");

	a_phase_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_04
		!soft_rst |=> (acc_r == $past(acc_r) + PHASE_W'($past(exc_r[6:0]))))
		else $error("accumulator step differs from frequency word");

	a_soft_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_16
		soft_rst |=> (fault_r == 8'h00) && (acc_r == '0) && loop_restart_o && $stable(ctrl_r))
		else $error("soft reset effects missing");

	a_pin_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_18
		(fault_live != 8'h00) |=> !(tracking_loss_n_o && signal_degradation_n_o))
		else $error("fault not shown on pins");

	a_ro_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_23
		(data_wr && (addr_r == resolver_cfg_pkg::ADDR_FAULT || addr_r == resolver_cfg_pkg::ADDR_SRST))
		|=> $stable(ctrl_r) && $stable(exc_r) && $stable(tl_high_r) && $stable(tl_low_r))
		else $error("data write to read-only address changed a register");

	a_res_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_13
		cfg_mode |=> (out_res_o == {$past(ctrl_r[0]), $past(ctrl_r[1])}))
		else $error("config mode resolution not from control bits");

	a_res_pins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_20
		!cfg_mode |=> (out_res_o == {$past(pin_r[3]), $past(pin_r[4])}))
		else $error("normal mode resolution not from pins");

	a_ind_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_22
		clr_ind |=> (ind_r == $past(fault_live)))
		else $error("indications not cleared to live faults");

	a_fault_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_19
		(sample_fall && !soft_rst) |=> (fault_r == $past(fault_live)))
		else $error("fault register not latched on sample edge");

	// Bytes outside configuration mode must leave the address, control and excitation registers alone
	a_cfg_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_14
		(wr_stb_i && !cfg_mode) |=> $stable(addr_r) && $stable(ctrl_r) && $stable(exc_r))
		else $error("write accepted outside configuration mode");

	a_ctrl_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_15
		(addr_wr && (wr_byte_i == resolver_cfg_pkg::ADDR_CTRL)) |=>
		(rd_byte_o == {($past(^ctrl_r[6:0]) != $past(ctrl_r[7])), $past(ctrl_r[6:0])}))
		else $error("control readback or its error bit wrong");

	// A readback mismatch must reach the live parity fault bit
	a_parity_live: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_19
		(addr_wr && rb_mismatch) |=> fault_live[resolver_cfg_pkg::FLT_PARITY])
		else $error("parity mismatch not flagged as fault");

endmodule
`default_nettype wire

// *** include/resolver_cfg_pkg.sv ***
/*
 Constants, field layouts and helpers for the resolver converter
 configuration register bank.
 Assumes a 20 MHz reference clock that also drives the excitation
 phase accumulator.
*/
// How it works
// RULE_01: Seven-bit tracking-loss high threshold at 0x8D.
// RULE_02: Tracking-loss fault with high/low hysteresis.
// RULE_03: Threshold defaults follow the output resolution; the code always loads the 12-bit defaults.
// RULE_04: Excitation frequency is word times clock over 2^15.
// RULE_05: Host keeps frequency word within 0x4 to 0x50.
// RULE_06: Power-up frequency word gives 10 kHz.
// RULE_07: Control register at 0x92 resets to 0x7E.
// RULE_08: D6 reserved one; D5 selects phase lock range.
// RULE_09: D4 enables one-LSB position hysteresis.
// RULE_10: Hysteresis is enabled after power-up.
// RULE_11: Host resets after signal loss in 360 mode.
// RULE_12: D3/D2 pick encoder resolution, default 16 bits.
// RULE_13: Config mode uses control bits, else pins.
// RULE_14: D7 high means address, low means data.
// RULE_15: Stored parity in D7; readback flags mismatch.
// RULE_16: Address 0xF0 soft-resets loop, clears faults.
// RULE_17: Host may soft-reset converters to align phase.
// RULE_18: Faults pull output pins low, cause recorded.
// RULE_19: Fault bits: clip, loss, overrange ... parity.
// RULE_20: Resolution codes 00..11 map 10 to 16 bits.
// RULE_21: Host enters config mode with both selects high.
// RULE_22: Sample edge after fault read clears indicators.
// RULE_23: Data to read-only or reset address is ignored.
package resolver_cfg_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_TL_HIGH = 8'h8D;
	localparam logic [7:0] ADDR_TL_LOW  = 8'h8E;
	localparam logic [7:0] ADDR_EXC     = 8'h91;
	localparam logic [7:0] ADDR_CTRL    = 8'h92;
	localparam logic [7:0] ADDR_SRST    = 8'hF0;
	localparam logic [7:0] ADDR_FAULT   = 8'hFF;
	localparam int         FLAG_BIT     = 7;

	// Excitation timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int EXC_DEFAULT_HZ = 10_000;
	localparam int PHASE_BITS     = 15;
	localparam logic [6:0] FCW_DEFAULT =
		7'(EXC_DEFAULT_HZ * (2 ** PHASE_BITS) / CLK_HZ);

	// Resolution codes, first bit then second bit
	localparam logic [1:0] RES_10 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_14 = 2'h2;
	localparam logic [1:0] RES_16 = 2'h3;

	// Control field layout, data bits D6..D0
	typedef struct packed {
		logic       reserved_one; // D6
		logic       lock_narrow;  // D5, one is +-44 degrees
		logic       hyst_en;      // D4
		logic       enc_res_hi;   // D3
		logic       enc_res_lo;   // D2
		logic       out_res_hi;   // D1
		logic       out_res_lo;   // D0
	} ctrl_t;
	localparam logic [6:0] CTRL_DEFAULT = 7'h7E;

	// Fault bit positions
	localparam int FLT_CLIP   = 7;
	localparam int FLT_LOSS   = 6;
	localparam int FLT_OVER   = 5;
	localparam int FLT_MISM   = 4;
	localparam int FLT_TRACK  = 3;
	localparam int FLT_VELO   = 2;
	localparam int FLT_PHASE  = 1;
	localparam int FLT_PARITY = 0;

	// Stored byte with parity in place of the flag bit
	function automatic logic [7:0] with_parity(input logic [6:0] d);
		return {^d, d};
	endfunction

	// Resolution code from a pin or bit pair
	function automatic logic [1:0] res_code(input logic first, input logic second);
		return {first, second};
	endfunction

	// Threshold defaults in LSB counts per resolution
	function automatic logic [13:0] tl_defaults(input logic [1:0] res);
		case (res)
			RES_10:  return {7'h07, 7'h24}; // 2.5 / 12.5 deg at 0.35
			RES_12:  return {7'h07, 7'h24}; // 1.0 / 5.0 deg at 0.14
			default: return {7'h06, 7'h1C}; // 0.5 / 2.5 deg at 0.09
		endcase
	endfunction

	localparam logic [13:0] TL_DEF = tl_defaults(RES_12);
	localparam logic [6:0]  TL_LOW_DEFAULT  = TL_DEF[13:7];
	localparam logic [6:0]  TL_HIGH_DEFAULT = TL_DEF[6:0];

endpackage

// *** test/resolver_host_model.sv ***
/*
 Host controller model: sets the mode pins, writes address and data
 bytes one strobe at a time, and pulses the sample pin.
 Assumes it shares the register bank's clock.
*/
`timescale 1ns/1ns
`default_nettype none
module resolver_host_model (
	input  wire logic       clk_i,
	output logic            mode_a_o,
	output logic            mode_b_o,
	output logic            sample_o,
	output logic            stb_o,
	output logic [7:0]      byte_o
);
	// Idle: normal mode, sample high, no strobe
	initial begin
		mode_a_o = 1'b0;
		mode_b_o = 1'b0;
		sample_o = 1'b1;
		stb_o = 1'b0;
		byte_o = 8'h00;
	end
	// Both selects high enter configuration mode; wait out the pin filter
	task automatic set_cfg(input logic on);
		@(posedge clk_i);
		mode_a_o <= on;
		mode_b_o <= on;
		repeat (6) @(posedge clk_i);
		#1;
	endtask
	// One byte, one strobe cycle, then the bus stops showing it
	task automatic wr(input logic [7:0] b);
		@(posedge clk_i);
		stb_o <= 1'b1;
		byte_o <= b;
		@(posedge clk_i);
		stb_o <= 1'b0;
		byte_o <= ~b;
	endtask
	// Address byte then data byte with its top bit low
	task automatic wr_reg(input logic [7:0] a, input logic [6:0] d);
		wr(a);
		wr({1'b0, d});
	endtask
	// Falling sample edge, held low, then time for the latch
	task automatic pulse_sample();
		@(posedge clk_i);
		sample_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		sample_o <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// *** test/resolver_converter_config_regs_tb_top.sv ***
/*
 Self-checking bench of the resolver configuration register bank.
 Assumes the package and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module resolver_converter_config_regs_tb_top;
	logic                    clk_sys_i;
	logic                    rst_n_i;
	logic                    res_lo;
	logic                    res_hi;
	logic [6:0]              track_err;
	logic [7:0]              fault_src;
	wire logic               mode_a, mode_b, sample, stb;
	wire logic [7:0]         wbyte;
	logic [7:0]              rd_byte;
	resolver_cfg_pkg::ctrl_t control;
	logic [1:0]              out_res;
	logic [14:0]             phase;
	logic [14:0]             p0;
	logic                    restart, cfg_mode, tl_n, deg_n;
	int                      mismatches = 0;
	int                      n_compared = 0;
	int                      cycles     = 0;
	logic [7:0]              ra [3] = '{8'h8D, 8'h8E, 8'h91};
	logic [6:0]              rv [3] = '{7'h30, 7'h05, 7'h50};
	logic [6:0]              fw [2] = '{7'h04, 7'h50};
	logic [6:0]              cv [2] = '{7'h55, 7'h6A};
	logic [7:0]              cr [2] = '{8'h02, 8'h01};
	int                      fb [6] = '{7, 6, 5, 4, 2, 1};

	// 20 MHz clock
	always #25 clk_sys_i = ~clk_sys_i;

	resolver_host_model u_host (.clk_i(clk_sys_i), .mode_a_o(mode_a), .mode_b_o(mode_b),
		.sample_o(sample), .stb_o(stb), .byte_o(wbyte));

	resolver_converter_config_regs u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.mode_select_a_i(mode_a), .mode_select_b_i(mode_b), .sample_i(sample),
		.output_resolution_sel_lo_i(res_lo), .output_resolution_sel_hi_i(res_hi),
		.wr_stb_i(stb), .wr_byte_i(wbyte), .track_err_i(track_err), .fault_src_i(fault_src),
		.rd_byte_o(rd_byte), .control_o(control), .out_res_o(out_res), .exc_phase_o(phase),
		.loop_restart_o(restart), .config_mode_o(cfg_mode), .tracking_loss_n_o(tl_n),
		.signal_degradation_n_o(deg_n));

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Address a register and compare the readback byte
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		u_host.wr(a);
		#1;
		chk(rd_byte, exp);
	endtask
	// Level inputs, changed at a rising edge
	task automatic set_in(input logic [6:0] e, input logic [7:0] f, input logic lo, input logic hi);
		@(posedge clk_sys_i);
		track_err <= e;
		fault_src <= f;
		res_lo <= lo;
		res_hi <= hi;
	endtask
	// Counts and verdict
	task automatic test_done();
		$display("Compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			test_done();
		end
	end

	// Test sequence
	initial begin
		clk_sys_i = 1'b0;
		rst_n_i   = 1'b0;
		res_lo    = 1'b0;
		res_hi    = 1'b0;
		track_err = 7'h00;
		fault_src = 8'h00;
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk({1'b0, control}, 8'h7E);
		chk({6'h00, out_res}, 8'h01);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		u_host.set_cfg(1'b1);
		chk({7'h00, cfg_mode}, 8'h01);
		rd(8'h8D, 8'h24);
		rd(8'h8E, 8'h07);
		rd(8'h91, 8'(10_000 * (2 ** 15) / resolver_cfg_pkg::CLK_HZ));
		rd(8'h92, 8'h7E);
		$display("Test defaults done");
		foreach (ra[i]) begin
			u_host.wr_reg(ra[i], rv[i]);
			rd(ra[i], {1'b0, rv[i]});
		end
		u_host.wr(8'h80);
		u_host.wr(8'h2A);
		rd(8'h80, 8'h00);
		rd(8'h91, {1'b0, rv[2]});
		foreach (fw[i]) begin
			u_host.wr_reg(8'h91, fw[i]);
			@(posedge clk_sys_i);
			#1;
			p0 = phase;
			@(posedge clk_sys_i);
			#1;
			chk(8'(15'(phase - p0)), {1'b0, fw[i]});
		end
		foreach (cv[i]) begin
			u_host.wr_reg(8'h92, cv[i]);
			#1;
			chk({1'b0, control}, {1'b0, cv[i]});
			@(posedge clk_sys_i);
			#1;
			chk({6'h00, out_res}, cr[i]);
			rd(8'h92, {1'b0, cv[i]});
		end
		$display("Test write readback done");
		set_in(7'h30, 8'h00, 1'b0, 1'b0);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({7'h00, tl_n}, 8'h01);
		set_in(7'h31, 8'h00, 1'b0, 1'b0);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({7'h00, tl_n}, 8'h00);
		set_in(7'h05, 8'h00, 1'b0, 1'b0);
		u_host.pulse_sample();
		rd(8'hFF, 8'h08);
		set_in(7'h04, 8'h00, 1'b0, 1'b0);
		u_host.pulse_sample();
		#1;
		chk({7'h00, tl_n}, 8'h01);
		$display("Test tracking loss done");
		foreach (fb[i]) begin
			set_in(7'h00, 8'h00, 1'b0, 1'b0);
			u_host.wr(8'hF0);
			#1;
			chk({7'h00, restart}, 8'h01);
			chk(8'(phase), 8'h00);
			set_in(7'h00, 8'h01 << fb[i], 1'b0, 1'b0);
			u_host.pulse_sample();
			rd(8'hFF, 8'h01 << fb[i]);
			chk({6'h00, tl_n, deg_n}, {6'h00, ~|(fault_src & 8'h0E), ~|(fault_src & 8'hF1)});
		end
		rd(8'h92, 8'h6A);
		$display("Test faults done");
		set_in(7'h00, 8'h00, 1'b1, 1'b1);
		u_host.set_cfg(1'b0);
		chk({6'h00, out_res}, 8'h03);
		set_in(7'h00, 8'h00, 1'b1, 1'b0);
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk({6'h00, out_res}, 8'h02);
		u_host.wr_reg(8'h92, 7'h7E);
		u_host.set_cfg(1'b1);
		chk({1'b0, control}, 8'h6A);
		$display("Test normal mode done");
		test_done();
	end
endmodule
`default_nettype wire
